// file: src/uml_pkg.sv
/*
  Package for the universal macrocell logic array: sizes, register map of the
  AXI4-Lite configuration port, field positions, reset values and carrier types.
  Assumes a single 50 MHz clock domain and 32-bit AXI4-Lite data.
*/
package uml_pkg;
  // Array geometry
  localparam int UML_CELLS = 8;
  localparam int UML_PINS_IN = 8;
  localparam int UML_TERMS = 8;
  // Array inputs: 8 dedicated pins, 8 feedbacks
  localparam int UML_ARRAY_IN = 16;
  // AND plane columns: true and complement per array input
  localparam int UML_COLS = 32;
  // Register byte offsets
  localparam logic [7:0] UML_ADDR_CONFIG = 8'h00;
  localparam logic [7:0] UML_ADDR_STATUS = 8'h04;
  localparam logic [7:0] UML_ADDR_TERM_SEL = 8'h08;
  localparam logic [7:0] UML_ADDR_TERM_LO = 8'h0C;
  localparam logic [7:0] UML_ADDR_TERM_HI = 8'h10;
  // Configuration word fields
  localparam int UML_CFG_MODE_POS = 0;
  localparam int UML_CFG_POL_POS = 8;
  localparam int UML_CFG_PERMIT_POS = 16;
  localparam int UML_CFG_FAMILY_POS = 17;
  // Reset values
  localparam logic [17:0] UML_CFG_RESET = 18'h2_0000; // Permit set, family clear: combinatorial outputs
  localparam logic [31:0] UML_TERM_RESET = 32'h0000_0000;
  // Term selector width: 64 product terms
  localparam int UML_SEL_W = 6;
  localparam logic [1:0] UML_RESP_OKAY = 2'b00;
  localparam logic [1:0] UML_RESP_SLVERR = 2'b10;

  // Decoded per-cell configuration
  typedef struct packed {
    logic register_permit_bit;
    logic family_emulation_bit;
    logic [UML_CELLS-1:0] cell_mode_bit;
    logic [UML_CELLS-1:0] cell_polarity_bit;
  } uml_cfg_type;

  // Cell pin pair; output enable active low
  typedef struct packed {
    logic [UML_CELLS-1:0] pin_out;
    logic [UML_CELLS-1:0] pin_oe_n;
  } uml_pins_type;
endpackage : uml_pkg

// file: src/uml_array.sv
/*
  Universal macrocell logic array: programmable AND plane, fixed OR plane and
  eight configurable macrocells, configured over AXI4-Lite.
  Assumes pins arrive asynchronously and pass two flip-flops; the common
  register clock is a sampled pin turned into a one-cycle rising-edge enable.
*/
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module uml_array
  import uml_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [UML_PINS_IN-1:0] in_pin,
  input wire logic clk_pin,
  input wire logic oe_n_pin,
  input wire logic [UML_CELLS-1:0] io_pin_in,
  output uml_pins_type io_pins,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  uml_cfg_type cfg;
  logic [UML_SEL_W-1:0] term_sel;
  logic [UML_COLS-1:0] term_mem [UML_CELLS*UML_TERMS];
  logic [UML_PINS_IN-1:0] in_meta, in_sync;
  logic [UML_CELLS-1:0] io_meta, io_sync;
  logic clk_meta, clk_sync, clk_prev, oe_meta, oe_sync;
  logic clk_rise;
  logic [UML_CELLS-1:0] cell_q;
  logic [UML_CELLS-1:0] feedback;
  logic [UML_CELLS-1:0] sum;
  logic [UML_CELLS-1:0] oe_term;
  logic [UML_CELLS-1:0] next_out;
  logic [UML_CELLS-1:0] next_oe_n;
  logic [UML_ARRAY_IN-1:0] array_in;
  logic [UML_COLS-1:0] cols;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic regs_mode;

  // Registered device when permit is low and family is high
  assign regs_mode = !cfg.register_permit_bit && cfg.family_emulation_bit;

  // Two-stage synchronisers for every pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_meta <= '0;
      in_sync <= '0;
      io_meta <= '0;
      io_sync <= '0;
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
      oe_meta <= 1'b1;
      oe_sync <= 1'b1;
    end else begin
      in_meta <= in_pin;
      in_sync <= in_meta;
      io_meta <= io_pin_in;
      io_sync <= io_meta;
      clk_meta <= clk_pin;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      oe_meta <= oe_n_pin;
      oe_sync <= oe_meta;
    end
  end

  // Common register clock becomes a one-cycle enable on its rising edge
  assign clk_rise = clk_sync && !clk_prev;

  // Array input vector: dedicated pins then cell feedbacks
  assign array_in = {feedback, in_sync};

  // True and complement columns for the AND plane
  generate
    for (genvar k = 0; k < UML_ARRAY_IN; k++) begin : g_cols
      assign cols[2*k] = array_in[k];
      assign cols[2*k+1] = !array_in[k];
    end
  endgenerate

  // Per-cell muxes, sum of products, polarity and buffer control
  generate
    for (genvar c = 0; c < UML_CELLS; c++) begin : g_cell
      logic [UML_TERMS-1:0] pt;
      logic io_mode, fb_ctrl, centre, adj;
      // Product term k is high when every connected column is high
      for (genvar t = 0; t < UML_TERMS; t++) begin : g_term
        // Unconnected columns are all-zero bits, so an empty term reads high
        assign pt[t] = &(cols | ~term_mem[c*UML_TERMS+t]);
      end
      assign io_mode = cfg.family_emulation_bit && cfg.cell_mode_bit[c];
      // Product-term input mux: eighth term moves to output enable in I/O mode
      assign sum[c] = io_mode ? |pt[UML_TERMS-2:0] : |pt;
      assign oe_term[c] = pt[UML_TERMS-1];
      // First and last cells steer feedback with the permit bit
      if (c == 0 || c == UML_CELLS-1) begin : g_edge
        assign fb_ctrl = !cfg.register_permit_bit;
        assign adj = (c == 0) ? oe_sync : clk_sync;
      end else begin : g_mid
        assign fb_ctrl = cfg.family_emulation_bit;
        assign adj = io_sync[c];
      end
      assign centre = (c == 3) || (c == 4);
      // Feedback select mux; edge cells take the shared pins whenever the permit bit is set
      always_comb begin
        if (regs_mode && !cfg.cell_mode_bit[c]) begin
          feedback[c] = !cell_q[c];
        end else if (!fb_ctrl && (c == 0 || c == UML_CELLS-1)) begin
          feedback[c] = adj;
        end else if (io_mode) begin
          feedback[c] = io_sync[c];
        end else if (cfg.cell_mode_bit[c]) begin
          feedback[c] = adj;
        end else if (centre) begin
          feedback[c] = 1'b0;
        end else begin
          feedback[c] = io_sync[c];
        end
      end
      // Output select and enable select muxes
      always_comb begin
        next_out[c] = sum[c] ^ !cfg.cell_polarity_bit[c];
        next_oe_n[c] = 1'b1;
        if (regs_mode && !cfg.cell_mode_bit[c]) begin
          next_out[c] = !cell_q[c];
          next_oe_n[c] = oe_sync;
        end else if (io_mode) begin
          next_oe_n[c] = !oe_term[c];
        end else if (!cfg.family_emulation_bit && !cfg.cell_mode_bit[c]) begin
          next_oe_n[c] = 1'b0;
        end else begin
          next_oe_n[c] = 1'b1;
        end
      end
    end
  endgenerate

  // Macrocell flip-flops; they reset low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cell_q <= '0;
    end else if (clk_rise && regs_mode) begin
      for (int c = 0; c < UML_CELLS; c++) begin
        if (!cfg.cell_mode_bit[c]) begin
          // Flip-flop stores inverted-polarity sum; pin shows its complement
          cell_q[c] <= !(sum[c] ^ !cfg.cell_polarity_bit[c]);
        end
      end
    end
  end

  // Pin drivers come from flip-flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_pins.pin_out <= '0;
      io_pins.pin_oe_n <= '1;
    end else begin
      io_pins.pin_out <= next_out;
      io_pins.pin_oe_n <= next_oe_n;
    end
  end

  // AXI4-Lite write channel capture
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= UML_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == UML_ADDR_CONFIG || aw_addr == UML_ADDR_TERM_SEL ||
          aw_addr == UML_ADDR_TERM_LO || aw_addr == UML_ADDR_TERM_HI) ? UML_RESP_OKAY : UML_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration word and term selector writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg <= UML_CFG_RESET;
      term_sel <= '0;
    end else if (aw_held && w_held) begin
      if (aw_addr == UML_ADDR_CONFIG) begin
        if (w_strb[0]) cfg.cell_mode_bit <= w_data[UML_CFG_MODE_POS +: UML_CELLS];
        if (w_strb[1]) cfg.cell_polarity_bit <= w_data[UML_CFG_POL_POS +: UML_CELLS];
        if (w_strb[2]) begin
          cfg.register_permit_bit <= w_data[UML_CFG_PERMIT_POS];
          cfg.family_emulation_bit <= w_data[UML_CFG_FAMILY_POS];
        end
      end else if (aw_addr == UML_ADDR_TERM_SEL && w_strb[0]) begin
        term_sel <= w_data[UML_SEL_W-1:0];
      end
    end
  end

  // AND-plane fuse memory: low word holds pin columns, high word feedback columns
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < UML_CELLS*UML_TERMS; i++) begin
        term_mem[i] <= UML_TERM_RESET;
      end
    end else if (aw_held && w_held) begin
      for (int b = 0; b < 2; b++) begin
        if (w_strb[b] && aw_addr == UML_ADDR_TERM_LO) begin
          term_mem[term_sel][8*b +: 8] <= w_data[8*b +: 8];
        end
        if (w_strb[b] && aw_addr == UML_ADDR_TERM_HI) begin
          term_mem[term_sel][16+8*b +: 8] <= w_data[8*b +: 8];
        end
      end
    end
  end

  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= UML_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= UML_RESP_OKAY;
      unique case (s_axi_araddr)
        UML_ADDR_CONFIG: s_axi_rdata <= {14'h0000, cfg.family_emulation_bit, cfg.register_permit_bit,
          cfg.cell_polarity_bit, cfg.cell_mode_bit};
        UML_ADDR_STATUS: s_axi_rdata <= {8'h00, cell_q, ~io_pins.pin_oe_n, io_pins.pin_out};
        UML_ADDR_TERM_SEL: s_axi_rdata <= {26'h000_0000, term_sel};
        UML_ADDR_TERM_LO: s_axi_rdata <= {16'h0000, term_mem[term_sel][15:0]};
        UML_ADDR_TERM_HI: s_axi_rdata <= {16'h0000, term_mem[term_sel][31:16]};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= UML_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the macrocell behaviour
  AST_REG_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_rise && regs_mode && !cfg.cell_mode_bit[1])
      |=> (cell_q[1] == !$past(sum[1] ~^ cfg.cell_polarity_bit[1])))
    else $error("registered cell did not capture sum");
  AST_REG_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_rise |=> $stable(cell_q))
    else $error("flip-flop changed without clock edge");
  AST_REG_OE: assert property (@(posedge clk) disable iff (!rst_n)
    (regs_mode && !cfg.cell_mode_bit[2]) |=> io_pins.pin_oe_n[2] == $past(oe_sync))
    else $error("registered buffer ignored enable pin");
  AST_INPUT_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.register_permit_bit && !cfg.family_emulation_bit && cfg.cell_mode_bit[5]) |=> io_pins.pin_oe_n[5])
    else $error("dedicated input buffer enabled");
  AST_COMB_ON: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg.family_emulation_bit && !cfg.cell_mode_bit[6]) |=> !io_pins.pin_oe_n[6])
    else $error("combinatorial output buffer not enabled");
  AST_IO_OE: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.family_emulation_bit && cfg.cell_mode_bit[3]) |=> io_pins.pin_oe_n[3] == !$past(oe_term[3]))
    else $error("I/O enable not from eighth term");
  AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_n)
    (!regs_mode || cfg.cell_mode_bit[4]) |=> io_pins.pin_out[4] == ($past(sum[4]) ~^ $past(cfg.cell_polarity_bit[4])))
    else $error("output polarity wrong");
  AST_REG_FB: assert property (@(posedge clk) disable iff (!rst_n)
    (regs_mode && !cfg.cell_mode_bit[2]) |-> feedback[2] == !cell_q[2])
    else $error("registered feedback not inverted");
  AST_EDGE_FB: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.register_permit_bit && !cfg.cell_mode_bit[7] && !cfg.family_emulation_bit) |-> feedback[7] == clk_sync)
    else $error("clock pin not routed through last cell");

  // Checks on feedback routing, product terms, output polarity and flip-flop use
  AST_OE_PIN_FB: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.register_permit_bit |-> feedback[0] == oe_sync)
    else $error("enable pin not routed through first cell");
  AST_CLK_PIN_FB: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.register_permit_bit |-> feedback[UML_CELLS-1] == clk_sync)
    else $error("clock pin not an array input without registers");
  AST_EDGE_IO_FB: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg.register_permit_bit && cfg.family_emulation_bit && cfg.cell_mode_bit[0]) |-> feedback[0] == io_sync[0])
    else $error("first cell in registered device ignored its pin");
  AST_IO_FB: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.register_permit_bit && cfg.family_emulation_bit && cfg.cell_mode_bit[2]) |-> feedback[2] == io_sync[2])
    else $error("I/O pin level not fed back");
  AST_CENTRE_FB: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.register_permit_bit && !cfg.family_emulation_bit && !cfg.cell_mode_bit[3]) |-> !feedback[3])
    else $error("centre cell fed back in combinatorial output mode");
  AST_COMB_FB: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.register_permit_bit && !cfg.family_emulation_bit && !cfg.cell_mode_bit[2]) |-> feedback[2] == io_sync[2])
    else $error("combinatorial output cell lost its feedback");
  AST_INPUT_FB: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.register_permit_bit && !cfg.family_emulation_bit && cfg.cell_mode_bit[5]) |-> feedback[5] == io_sync[5])
    else $error("dedicated input not taken from its pin");
  AST_TERM_EMPTY: assert property (@(posedge clk) disable iff (!rst_n)
    (term_mem[0] == UML_TERM_RESET) |-> g_cell[0].pt[0])
    else $error("empty product term not high");
  AST_TERM_BOTH: assert property (@(posedge clk) disable iff (!rst_n)
    (term_mem[1][1:0] == 2'b11) |-> !g_cell[0].pt[1])
    else $error("term with input and complement not low");
  AST_REG_EIGHT: assert property (@(posedge clk) disable iff (!rst_n)
    (regs_mode && !cfg.cell_mode_bit[6] && g_cell[6].pt == 8'h80) |-> sum[6])
    else $error("eighth term missing from registered sum");
  AST_IO_SEVEN: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.family_emulation_bit && cfg.cell_mode_bit[6] && g_cell[6].pt == 8'h80) |-> !sum[6])
    else $error("eighth term leaked into I/O sum");
  AST_POL_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.register_permit_bit && !cfg.family_emulation_bit && !cfg.cell_mode_bit[1] && !cfg.cell_polarity_bit[1]
      && sum[1]) |=> !io_pins.pin_out[1])
    else $error("active-low output drove high on a true sum");
  AST_NO_REGS: assert property (@(posedge clk) disable iff (!rst_n)
    !regs_mode |=> $stable(cell_q))
    else $error("flip-flop changed while registers not permitted");
  AST_FF_RESET: assert property (@(posedge clk)
    !rst_n |=> (cell_q == '0))
    else $error("flip-flops not low after reset");
endmodule : uml_array

// file: tb/uml_board.sv
/*
  Board model for the macrocell array: resolves each cell pin from the
  array drive and the board's own weak drive, and feeds the level back.
  Assumes the bench supplies the board drive for every pin at all times.
*/
`timescale 1ns/1ps
module uml_board
  import uml_pkg::*;
(
  input wire uml_pins_type io_pins,
  input wire logic [UML_CELLS-1:0] board_drive,
  output logic [UML_CELLS-1:0] io_pin_in
);
  // Pin level: array wins while enabled, otherwise the board drive sets the level
  always_comb begin
    for (int k = 0; k < UML_CELLS; k++) begin
      io_pin_in[k] = (io_pins.pin_oe_n[k] == 1'b0) ? io_pins.pin_out[k] : board_drive[k];
    end
  end
endmodule : uml_board

// file: tb/universal_macrocell_logic_array_bench.sv
/*
  Self-checking bench for the macrocell array: configures it over AXI4-Lite
  and checks pin behaviour in every cell mode.
  Assumes the package register map and the three-cycle pin latency.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module universal_macrocell_logic_array_bench;
  import uml_pkg::*;
  logic clk = 0, rst_n = 0, clk_pin = 0, oe_n_pin = 1;
  logic [7:0] in_pin = 8'h00, board_drive = 8'h00, io_pin_in, awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  uml_pins_type io_pins;
  int errors = 0, n_compared = 0;
  // Clock at 50 MHz
  always #10 clk = ~clk;
  uml_array uml_array_i (.clk(clk), .rst_n(rst_n), .in_pin(in_pin), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin),
    .io_pin_in(io_pin_in), .io_pins(io_pins), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  uml_board uml_board_i (.io_pins(io_pins), .board_drive(board_drive), .io_pin_in(io_pin_in));
  // AXI write: address and data offered together, each released when taken
  task automatic axi_w(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_w
  // AXI read: hold rready until the answer is sampled
  task automatic axi_r(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata; r = rresp;
    rready <= 1'b0;
  endtask : axi_r
  // Write with OKAY expected
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_w(a, d, rsp);
    `CHK(rsp, UML_RESP_OKAY)
  endtask : wr
  // Program one product term: pin columns and feedback columns
  task automatic term(input int sel, input logic [15:0] lo, input logic [15:0] hi);
    wr(UML_ADDR_TERM_SEL, 32'(sel));
    wr(UML_ADDR_TERM_LO, {16'h0000, lo});
    wr(UML_ADDR_TERM_HI, {16'h0000, hi});
  endtask : term
  // Let pin changes pass synchronisers and output register
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle
  // Common register clock pulse on the shared pin
  task automatic pulse_clk_pin;
    clk_pin <= 1'b1; settle(4); clk_pin <= 1'b0; settle(4);
  endtask : pulse_clk_pin
  // Reset values, default combinatorial output, unmapped access
  task automatic t_reset;
    axi_r(UML_ADDR_CONFIG, rd, rsp);
    `CHK(rd, 32'h0001_0000)
    settle(4);
    `CHK(io_pins.pin_oe_n, 8'h00)
    `CHK(io_pins.pin_out, 8'h00)
    axi_r(8'h20, rd, rsp);
    `CHK(rsp, UML_RESP_SLVERR)
    `CHK(rd, 32'h0000_0000)
    axi_w(8'h24, 32'hFFFF_FFFF, rsp);
    `CHK(rsp, UML_RESP_SLVERR)
  endtask : t_reset
  // Sum of products on cell 0 with true and complement columns
  task automatic t_comb;
    for (int t = 1; t < 8; t++) term(t, 16'h0003, 16'h0000);
    term(0, 16'h0001, 16'h0000);
    wr(UML_ADDR_CONFIG, 32'h0001_FF00);
    for (int v = 0; v < 2; v++) begin
      in_pin[0] <= v[0]; settle(4);
      `CHK(io_pins.pin_out, {7'h7F, v[0]})
    end
    term(0, 16'h0002, 16'h0000);
    axi_r(UML_ADDR_TERM_LO, rd, rsp);
    `CHK(rd, 32'h0000_0002)
    settle(4);
    `CHK(io_pins.pin_out[0], 1'b0)
    wr(UML_ADDR_CONFIG, 32'h0001_FE00); settle(4);
    `CHK(io_pins.pin_out[0], 1'b1)
  endtask : t_comb
  // Registered cells: power-up level, enable pin, capture on clock pin
  task automatic t_reg;
    term(0, 16'h0001, 16'h0000);
    in_pin[0] <= 1'b0;
    wr(UML_ADDR_CONFIG, 32'h0002_FF00); settle(4);
    `CHK(io_pins.pin_out, 8'hFF)
    `CHK(io_pins.pin_oe_n, 8'hFF)
    axi_r(UML_ADDR_STATUS, rd, rsp);
    `CHK(rd, 32'h0000_00FF)
    oe_n_pin <= 1'b0; settle(4);
    `CHK(io_pins.pin_oe_n, 8'h00)
    pulse_clk_pin;
    `CHK(io_pins.pin_out, 8'hFE)
    axi_r(UML_ADDR_STATUS, rd, rsp);
    `CHK(rd, 32'h0001_FFFE)
    in_pin[0] <= 1'b1; settle(4);
    `CHK(io_pins.pin_out, 8'hFE)
    pulse_clk_pin;
    `CHK(io_pins.pin_out, 8'hFF)
  endtask : t_reg
  // I/O cells: eighth term enables, pin level fed back into array
  task automatic t_io;
    term(0, 16'h0000, 16'h0004);
    term(7, 16'h0000, 16'h0000);
    term(15, 16'h0003, 16'h0000);
    wr(UML_ADDR_CONFIG, 32'h0003_FFFF);
    for (int v = 0; v < 2; v++) begin
      board_drive[1] <= v[0]; settle(5);
      `CHK(io_pins.pin_oe_n[1:0], 2'b10)
      `CHK(io_pins.pin_out[0], v[0])
    end
  endtask : t_io
  // Dedicated inputs keep every buffer off
  task automatic t_input;
    wr(UML_ADDR_CONFIG, 32'h0001_00FF); settle(4);
    `CHK(io_pins.pin_oe_n, 8'hFF)
  endtask : t_input
  // Verdict and end of run
  task automatic end_of_test;
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset; t_comb; t_reg; t_io; t_input;
    end_of_test;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test;
  end
endmodule : universal_macrocell_logic_array_bench
